// ==== src/usr4_pkg.sv ====
// shared constants and types for the four-stage universal shift register
// assumes a single 100 MHz system clock; all pins are asynchronous to it

package usr4_pkg;

	// ***************************************************
	// sizes and reset values
	// ***************************************************
	localparam int unsigned USR4_STAGES     = 4;
	localparam int unsigned USR4_FIFO_DEPTH = 4;
	localparam logic [3:0]  USR4_STAGE_RST  = 4'h0;
	localparam int unsigned USR4_CLK_NS     = 10;

	// ***************************************************
	// bit positions inside the sampled pin vector
	// ***************************************************
	localparam int unsigned USR4_PIN_CLEAR_N = 0;
	localparam int unsigned USR4_PIN_SEL_LO  = 1;
	localparam int unsigned USR4_PIN_SEL_HI  = 2;
	localparam int unsigned USR4_PIN_SCLK    = 3;
	localparam int unsigned USR4_PIN_SER_L   = 4;
	localparam int unsigned USR4_PIN_SER_R   = 5;
	localparam int unsigned USR4_PIN_PAR_LSB = 6;
	localparam int unsigned USR4_PIN_W       = 10;

	// ***************************************************
	// types
	// ***************************************************
	typedef logic [USR4_STAGES-1:0] usr4_stage_t;
	typedef logic [USR4_PIN_W-1:0]  usr4_pins_t;

	typedef enum logic [1:0] {
		USR4_HOLD,
		USR4_SHIFT_RIGHT,
		USR4_SHIFT_LEFT,
		USR4_LOAD
	} usr4_mode_t;

	typedef struct packed {
		usr4_pins_t  sync1;
		usr4_pins_t  sync2;
		usr4_pins_t  sync3;
		usr4_pins_t  pins;
		usr4_stage_t stages;
		usr4_mode_t  mode;
		logic        push_valid;
		usr4_stage_t push_data;
		logic        lost;
		logic        space;
	} usr4_core_t;

	// mode select pair to operating mode
	function automatic usr4_mode_t usr4_decode_mode(input logic sel_hi,
		input logic sel_lo);
		usr4_mode_t m;
		m = USR4_HOLD;
		case ({sel_hi, sel_lo})
			2'h0: m = USR4_HOLD;
			2'h1: m = USR4_SHIFT_RIGHT;
			2'h2: m = USR4_SHIFT_LEFT;
			default: m = USR4_LOAD;
		endcase
		return m;
	endfunction

endpackage

// ==== src/usr4_fifo.sv ====
// small shift-style FIFO carrying register snapshots to a consumer
// assumes producer and consumer share the clock; head entry is a flop

`timescale 1ns/100ps

module usr4_fifo #(
	parameter int unsigned WIDTH = 4,
	parameter int unsigned DEPTH = 4
) (
	input  wire logic             ref_clk,   // system clock
	input  wire logic             reset_n,   // async reset, active low
	input  wire logic             in_valid,  // producer offers a word
	output logic                  in_ready,  // room for one more word
	input  wire logic [WIDTH-1:0] in_data,   // word offered
	output logic                  out_valid, // head word present
	input  wire logic             out_ready, // consumer takes head
	output logic [WIDTH-1:0]      out_data   // head word
);

	generate
		if (WIDTH < 1 || DEPTH < 2) begin : g_bad_size
			$error("usr4_fifo needs WIDTH >= 1 and DEPTH >= 2");
		end
	endgenerate

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] data;
		logic [DEPTH-1:0]            vld;
	} usr4_fifo_t;

	usr4_fifo_t s;
	usr4_fifo_t next_s;
	logic       placed;

	// ***************************************************
	// next state
	// ***************************************************
	always_comb begin
		next_s = s;
		placed = 1'b0;
		// pop first so a push lands behind the words that remain; a full
		// queue still refuses, as ready ignores out_ready
		if (out_ready && s.vld[0]) begin
			for (int i = 0; i < DEPTH - 1; i++) begin
				next_s.data[i] = s.data[i+1];
				next_s.vld[i]  = s.vld[i+1];
			end
			next_s.data[DEPTH-1] = '0;
			next_s.vld[DEPTH-1]  = 1'b0;
		end
		if (in_valid && in_ready) begin
			for (int i = 0; i < DEPTH; i++) begin
				if (!placed && !next_s.vld[i]) begin
					next_s.data[i] = in_data;
					next_s.vld[i]  = 1'b1;
					placed         = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	// ready looks only at stored state, never at out_ready
	assign in_ready  = !s.vld[DEPTH-1];
	assign out_valid = s.vld[0];
	assign out_data  = s.data[0];

endmodule

// ==== src/usr4_shift_reg.sv ====
// four-stage bidirectional universal shift register behind sampled pins
// assumes all control and data pins are asynchronous to ref_clk; the
// external shift clock is a pin sampled like the rest, so its rising
// edge acts some cycles later than it occurs on the board
//
// Notes on behaviour
// - four stages, shift either way or load
// - clear low forces all stages low
// - clock low keeps stages unchanged
// - stages change only on rising clock or clear low
// - both selects high load parallel inputs
// - select low-high shifts right from right input
// - select high-low shifts left from left input
// - shifting ignores parallel inputs
// - both selects low hold stages

`timescale 1ns/100ps

module usr4_shift_reg
	import usr4_pkg::*;
#(
	parameter int unsigned FIFO_DEPTH = USR4_FIFO_DEPTH
) (
	input  wire logic           ref_clk,      // system clock, 100 MHz
	input  wire logic           reset_n,      // async reset, active low
	input  wire logic           clear_n,      // clear pin, active low
	input  wire logic           mode_sel_hi,  // mode select high bit
	input  wire logic           mode_sel_lo,  // mode select low bit
	input  wire logic           shift_clk,    // register clock pin
	input  wire logic           serial_left,  // serial in, shift left
	input  wire logic           serial_right, // serial in, shift right
	input  wire logic [3:0]     par_in,       // parallel data, bit 0 first
	output logic                stage_out_0,  // first stage
	output logic                stage_out_1,  // second stage
	output logic                stage_out_2,  // third stage
	output logic                stage_out_3,  // last stage
	output usr4_pkg::usr4_mode_t mode_now,    // mode now in force
	output logic                snap_valid,   // snapshot word present
	input  wire logic           snap_ready,   // consumer takes snapshot
	output usr4_pkg::usr4_stage_t snap_data,  // stage contents snapshot
	output logic                snap_space,   // snapshot queue had room
	output logic                snap_lost     // sticky: snapshot dropped
);

	import usr4_pkg::*;

	generate
		if (FIFO_DEPTH < 2) begin : g_bad_depth
			$error("usr4_shift_reg needs FIFO_DEPTH >= 2");
		end
	endgenerate

	// ***************************************************
	// state
	// ***************************************************
	localparam usr4_core_t CORE_RST = '{
		sync1:      '0,
		sync2:      '0,
		sync3:      '0,
		pins:       '0,
		stages:     USR4_STAGE_RST,
		mode:       USR4_HOLD,
		push_valid: 1'b0,
		push_data:  USR4_STAGE_RST,
		lost:       1'b0,
		space:      1'b0
	};

	usr4_core_t  s;
	usr4_core_t  next_s;
	usr4_pins_t  pin_vec;
	logic        clk_rise;
	logic        fifo_in_ready;
	usr4_mode_t  mode;

	assign pin_vec = {par_in, serial_right, serial_left, shift_clk,
		mode_sel_hi, mode_sel_lo, clear_n};

	// ***************************************************
	// next state
	// ***************************************************
	always_comb begin
		next_s   = s;
		clk_rise = 1'b0;
		mode     = USR4_HOLD;

		// three-stage pin sampling; a level counts once the last two agree
		next_s.sync1 = pin_vec;
		next_s.sync2 = s.sync1;
		next_s.sync3 = s.sync2;
		for (int i = 0; i < USR4_PIN_W; i++) begin
			if (s.sync2[i] == s.sync3[i]) begin
				next_s.pins[i] = s.sync2[i];
			end
		end

		// settled levels only
		// every pin passes the same filter, so mode and data seen with a
		// clock edge are the levels sampled in the same ref_clk cycle as that edge
		mode        = usr4_decode_mode(next_s.pins[USR4_PIN_SEL_HI],
			next_s.pins[USR4_PIN_SEL_LO]);
		next_s.mode = mode;

		clk_rise = next_s.pins[USR4_PIN_SCLK] && !s.pins[USR4_PIN_SCLK];

		if (!next_s.pins[USR4_PIN_CLEAR_N]) begin
			next_s.stages = USR4_STAGE_RST;
		end else if (clk_rise) begin
			case (mode)
				USR4_LOAD: begin
					next_s.stages = next_s.pins[USR4_PIN_PAR_LSB +:
						USR4_STAGES];
				end
				USR4_SHIFT_RIGHT: begin
					next_s.stages = {s.stages[USR4_STAGES-2:0],
						next_s.pins[USR4_PIN_SER_R]};
				end
				USR4_SHIFT_LEFT: begin
					next_s.stages = {next_s.pins[USR4_PIN_SER_L],
						s.stages[USR4_STAGES-1:1]};
				end
				USR4_HOLD: begin
					next_s.stages = s.stages;
				end
				default: begin
					next_s.stages = s.stages;
				end
			endcase
		end

		// every change of contents is offered once to the snapshot queue
		next_s.push_valid = (next_s.stages != s.stages);
		next_s.push_data  = next_s.stages;

		// a refused offer is dropped rather than stalling the register,
		// which must follow the pins; a new drop beats a clear
		if (s.push_valid && !fifo_in_ready) begin
			next_s.lost = 1'b1;
		end else if (!next_s.pins[USR4_PIN_CLEAR_N]) begin
			next_s.lost = 1'b0;
		end
		next_s.space = fifo_in_ready;
	end

	// ***************************************************
	// registers
	// ***************************************************
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			s <= CORE_RST;
		end else begin
			s <= next_s;
		end
	end

	// ***************************************************
	// snapshot queue
	// ***************************************************
	usr4_fifo #(
		.WIDTH (USR4_STAGES),
		.DEPTH (FIFO_DEPTH)
	) u_snap_fifo (
		.ref_clk   (ref_clk),
		.reset_n   (reset_n),
		.in_valid  (s.push_valid),
		.in_ready  (fifo_in_ready),
		.in_data   (s.push_data),
		.out_valid (snap_valid),
		.out_ready (snap_ready),
		.out_data  (snap_data)
	);

	// ***************************************************
	// outputs
	// ***************************************************
	// four stage outputs
	assign stage_out_0 = s.stages[0];
	assign stage_out_1 = s.stages[1];
	assign stage_out_2 = s.stages[2];
	assign stage_out_3 = s.stages[3];
	assign mode_now    = s.mode;
	assign snap_space  = s.space;
	assign snap_lost   = s.lost;

endmodule

// ==== verification/usr4_sva.sv ====
// assertions on the shift register top, bound after the module
// assumes a pin filter latency of three to four ref_clk cycles
`timescale 1ns/100ps
module usr4_sva
	import usr4_pkg::*;
(
	input wire logic        ref_clk,     // clk
	input wire logic        reset_n,     // rst
	input wire logic        clear_n,     // pin
	input wire logic        mode_sel_hi, // pin
	input wire logic        mode_sel_lo, // pin
	input wire logic        shift_clk,   // pin
	input wire logic        stage_out_0, // out
	input wire logic        stage_out_1, // out
	input wire logic        stage_out_2, // out
	input wire logic        stage_out_3, // out
	input wire usr4_mode_t  mode_now,    // out
	input wire logic        snap_valid,  // out
	input wire logic        snap_ready,  // in
	input wire usr4_stage_t snap_data,   // out
	input wire logic        snap_space,  // out
	input wire logic        snap_lost    // out
);
	logic [3:0] stg;
	assign stg = {stage_out_3, stage_out_2, stage_out_1, stage_out_0};
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	a_clear_zero: assert property (!clear_n [*7] |-> stg == 4'h0)
		else $error("stages not cleared");
	a_clk_low: assert property (
		(clear_n && !shift_clk) [*7] |=> $stable(stg))
		else $error("stages moved with clock low");
	a_clk_high: assert property (
		(clear_n && shift_clk) [*7] |=> $stable(stg))
		else $error("stages moved with clock high");
	a_hold_mode: assert property (
		(clear_n && !mode_sel_hi && !mode_sel_lo) [*7] |=> $stable(stg))
		else $error("stages moved in hold");
	a_mode_now: assert property (
		$stable({mode_sel_hi, mode_sel_lo}) [*7]
		|-> mode_now == {mode_sel_hi, mode_sel_lo})
		else $error("bad mode");
	a_snap_push: assert property ($changed(stg) && snap_space
		|-> ##[1:3] snap_valid) else $error("snapshot missing");
	a_snap_hold: assert property (snap_valid && !snap_ready
		|=> snap_valid && $stable(snap_data)) else $error("head lost");
	a_lost_keep: assert property (clear_n [*5] ##0 snap_lost
		|=> snap_lost) else $error("drop flag fell");
	c_load: cover property (mode_now == USR4_LOAD && $changed(stg));
	c_lost: cover property ($rose(snap_lost));
	c_pop: cover property (snap_valid && snap_ready);
endmodule
bind usr4_shift_reg usr4_sva u_sva (.ref_clk, .reset_n, .clear_n,
	.mode_sel_hi, .mode_sel_lo, .shift_clk, .stage_out_0, .stage_out_1,
	.stage_out_2, .stage_out_3, .mode_now, .snap_valid, .snap_ready,
	.snap_data, .snap_space, .snap_lost);

// ==== verification/usr4_sink.sv ====
// snapshot consumer model on the far side of the queue
// assumes the bench stalls it on purpose to fill the queue
`timescale 1ns/100ps
module usr4_sink (
	input  wire logic       ref_clk,    // clk
	input  wire logic       reset_n,    // rst
	input  wire logic       stall,      // refuse words
	input  wire logic       snap_valid, // head present
	output logic            snap_ready, // take head
	input  wire logic [3:0] snap_data,  // head word
	output logic [7:0]      got,        // words taken
	output logic [3:0]      last        // last word taken
);
	assign snap_ready = !stall;
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			got <= 8'h00;
			last <= 4'h0;
		end else if (snap_valid && snap_ready) begin
			got <= got + 8'h01;
			last <= snap_data;
		end
	end
endmodule

// ==== verification/usr4_shift_reg_tb.sv ====
// self-checking bench for the four-stage shift register
// assumes the consumer model takes snapshots unless stalled
`timescale 1ns/100ps
module usr4_shift_reg_tb;
	import usr4_pkg::*;
	logic        ref_clk = 1'b0;
	logic        reset_n, clear_n, shift_clk, stall;
	logic        mode_sel_hi, mode_sel_lo, serial_left, serial_right;
	logic [3:0]  par_in, exp, last;
	wire  [3:0]  stg;
	logic        snap_valid, snap_ready, snap_space, snap_lost;
	usr4_stage_t snap_data;
	usr4_mode_t  mode_now;
	logic [7:0]  got, n0;
	int          miscompares = 0, checked = 0;
	usr4_shift_reg dut (.ref_clk, .reset_n, .clear_n, .mode_sel_hi,
		.mode_sel_lo, .shift_clk, .serial_left, .serial_right, .par_in,
		.stage_out_0(stg[0]), .stage_out_1(stg[1]), .stage_out_2(stg[2]),
		.stage_out_3(stg[3]), .mode_now, .snap_valid, .snap_ready,
		.snap_data, .snap_space, .snap_lost);
	usr4_sink sink (.ref_clk, .reset_n, .stall, .snap_valid, .snap_ready,
		.snap_data, .got, .last);
	always #5 ref_clk = ~ref_clk;
	task automatic chk(input string what, input logic [3:0] e,
		input logic [3:0] g);
		checked++;
		if (g !== e) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	task automatic pins(input logic [1:0] m, input logic [3:0] p,
		input logic sl, input logic sr);
		{mode_sel_hi, mode_sel_lo} = m;
		par_in = p;
		serial_left = sl;
		serial_right = sr;
	endtask
	task automatic tick_clk();
		cyc(5);
		shift_clk = 1'b1;
		cyc(8);
		shift_clk = 1'b0;
		cyc(8);
	endtask
	task automatic t_shift();
		pins(2'h3, 4'hA, 1'b0, 1'b0);
		tick_clk();
		chk("load", 4'hA, stg);
		chk("mode", {2'h0, USR4_LOAD}, {2'h0, mode_now});
		exp = 4'hA;
		for (int i = 0; i < 4; i++) begin
			pins(i < 2 ? 2'h1 : 2'h2, ~exp, i == 2, i == 0);
			tick_clk();
			exp = i < 2 ? {exp[2:0], i == 0} : {i == 2, exp[3:1]};
			chk("shift", exp, stg);
		end
		chk("mode", {2'h0, USR4_SHIFT_LEFT}, {2'h0, mode_now});
		$display("shift test done");
	endtask
	task automatic t_hold();
		pins(2'h0, ~exp, 1'b1, 1'b1);
		tick_clk();
		chk("hold", exp, stg);
		chk("mode", {2'h0, USR4_HOLD}, {2'h0, mode_now});
		pins(2'h3, ~exp, 1'b1, 1'b1);
		cyc(12);
		chk("clk low", exp, stg);
		shift_clk = 1'b1;
		cyc(8);
		exp = ~exp;
		chk("rise", exp, stg);
		par_in = ~exp;
		cyc(8);
		chk("clk high", exp, stg);
		shift_clk = 1'b0;
		cyc(8);
		chk("fall", exp, stg);
		$display("hold test done");
	endtask
	task automatic t_fifo();
		n0 = got;
		stall = 1'b1;
		for (int i = 1; i < 7; i++) begin
			pins(2'h3, 4'(i), 1'b0, 1'b0);
			tick_clk();
		end
		chk("lost", 4'h1, {3'h0, snap_lost});
		chk("space", 4'h0, {3'h0, snap_space});
		stall = 1'b0;
		cyc(10);
		chk("count", 4'h4, 4'(got - n0));
		chk("last", 4'h4, last);
		$display("fifo test done");
	endtask
	task automatic t_clear();
		clear_n = 1'b0;
		pins(2'h3, 4'hF, 1'b1, 1'b1);
		tick_clk();
		chk("clear", 4'h0, stg);
		chk("lost clr", 4'h0, {3'h0, snap_lost});
		clear_n = 1'b1;
		cyc(8);
		chk("released", 4'h0, stg);
		$display("clear test done");
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		reset_n = 1'b0;
		clear_n = 1'b1;
		shift_clk = 1'b0;
		stall = 1'b0;
		pins(2'h0, 4'h0, 1'b0, 1'b0);
		cyc(8);
		reset_n = 1'b1;
		cyc(8);
		t_shift();
		t_hold();
		t_fifo();
		t_clear();
		tally_and_finish();
	end
	initial begin
		repeat (5000) @(posedge ref_clk);
		miscompares++;
		tally_and_finish();
	end
endmodule
